/* File: shared/kwdg_cfg.svh */
// Constants for the keyed watchdog and reset guard
// Assumes a 100 MHz core clock and a slow oscillator near 32 kHz
`ifndef KWDG_CFG_SVH
`define KWDG_CFG_SVH
// Wishbone register map, byte addresses
`define KWDG_ADR_W         4
`define KWDG_DAT_W         32
`define KWDG_ADR_CTRL      4'h0
`define KWDG_ADR_FLAGS     4'h4
`define KWDG_ADR_GUARD     4'h8
`define KWDG_ADR_STAT      4'hc
// Reset values
`define KWDG_CTRL_RST      8'h53
`define KWDG_GUARD_RST     8'h55
// Control fields
`define KWDG_KEY_MSB       7
`define KWDG_KEY_LSB       3
`define KWDG_SEL_MSB       2
`define KWDG_SEL_LSB       0
`define KWDG_KEY_EN        5'h0a
`define KWDG_KEY_DIS       5'h15
`define KWDG_SEL_LONG      3'h7
// Guard values with no effect
`define KWDG_GUARD_OK_A    8'h55
`define KWDG_GUARD_OK_B    8'haa
// Flag and status bit positions
`define KWDG_FLAG_GUARD    3
`define KWDG_FLAG_KEY      0
`define KWDG_FLAG_MSB      7
`define KWDG_FLAG_HI       4
`define KWDG_STAT_TO       0
`define KWDG_STAT_PDF      1
// Period exponents per select code
`define KWDG_EXP_0         8
`define KWDG_EXP_1         10
`define KWDG_EXP_2         12
`define KWDG_EXP_3         14
`define KWDG_EXP_4         15
`define KWDG_EXP_5         16
`define KWDG_EXP_6         17
`define KWDG_EXP_7         18
`define KWDG_CNT_W         18
`define KWDG_CNT_MAX       18'h3ffff
// Timing
`define KWDG_OSC_HZ        32000
`define KWDG_CLK_PERIOD_NS 10
`define KWDG_SRESET_NS     100000
`define KWDG_SRESET_CYC    ((`KWDG_SRESET_NS + `KWDG_CLK_PERIOD_NS - 1) / `KWDG_CLK_PERIOD_NS)
`endif

/* File: shared/kwdg_pkg.sv */
// Types and period lookup for the keyed watchdog
// Assumes kwdg_cfg.svh is on the include path
`include "kwdg_cfg.svh"
`default_nettype none
package kwdg_pkg;
   typedef logic [`KWDG_CNT_W-1:0] kwdg_cnt_t;
   typedef logic [`KWDG_SEL_MSB:`KWDG_SEL_LSB] kwdg_sel_t;
   typedef logic [`KWDG_KEY_MSB-`KWDG_KEY_LSB:0] kwdg_key_t;
   typedef enum {KWDG_SRST_IDLE, KWDG_SRST_WAIT, KWDG_SRST_FIRE} kwdg_srst_t;

   // Terminal count for a period select code
   function automatic kwdg_cnt_t kwdg_limit(input kwdg_sel_t sel);
      int e;
      case (sel)
         3'h0:    e = `KWDG_EXP_0;
         3'h1:    e = `KWDG_EXP_1;
         3'h2:    e = `KWDG_EXP_2;
         3'h3:    e = `KWDG_EXP_3;
         3'h4:    e = `KWDG_EXP_4;
         3'h5:    e = `KWDG_EXP_5;
         3'h6:    e = `KWDG_EXP_6;
         default: e = `KWDG_EXP_7;
      endcase
      kwdg_limit = kwdg_cnt_t'((64'h1 << e) - 64'h1);
   endfunction : kwdg_limit
endpackage : kwdg_pkg
`default_nettype wire

/* File: hdl/kwdg_sync.sv */
// Two-stage synchroniser for levels entering the core clock
// Assumes the input is a slow level or clock from outside
`default_nettype none
module kwdg_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         q    <= '0;
      end else begin
         s1_q <= d;
         q    <= s1_q;
      end
   end
endmodule : kwdg_sync
`default_nettype wire

/* File: hdl/kwdg_wdcount.sv */
// Watchdog counter running on slow oscillator ticks
// Assumes tick is a one-cycle pulse in the core clock domain
`default_nettype none
module kwdg_wdcount
   import kwdg_pkg::*;
(
   // Clock and reset
   input  wire logic      core_clk,
   input  wire logic      rst_n,
   // Control
   input  wire logic      tick,
   input  wire logic      clear,
   input  wire logic      enable,
   input  wire kwdg_cnt_t limit,
   // Status
   output kwdg_cnt_t      count_q,
   output logic           overflow_q
);
   logic at_end;

   // Above-limit catch covers a select shortened mid-count
   assign at_end = (count_q >= limit);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
      end else if (clear) begin
         count_q <= '0;
      end else if (enable && tick) begin
         if (at_end) begin
            count_q <= '0;
         end else begin
            count_q <= count_q + kwdg_cnt_t'(1);
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         overflow_q <= 1'b0;
      end else begin
         overflow_q <= !clear && enable && tick && at_end;
      end
   end
endmodule : kwdg_wdcount
`default_nettype wire

/* File: hdl/kwdg_top.sv */
// Keyed watchdog timer and reset guard with Wishbone registers
// Assumes core events come from same-clock logic; oscillator is a pin
//
// Overview of operation
// - Count slow oscillator ticks, power-of-two timeout
// - Period codes 0 to 6 give 2^8..2^17
// - Key 10101 disables, 01010 enables, else reset
// - Bad key reset sets key reset flag
// - Key field powers up as enable
// - Running timeout: full reset, timeout flag set
// - Standby timeout resets only PC and SP
// - Count cleared by key reset, clear, halt
// - Guard reset sets flag bit 3, software clears
// - Key reset sets flag bit 0, software clears
// - Flag bits 7 to 4 read zero
// - Guard 55h or aah inert, else delayed reset
// - Guard register powers up at 55h
// - Power-on reset zeroes program counter
// - Power-on reset drives port registers high
// - Halt sets power-down, clears timeout and count
// - Standby timeout leaves timeout, power-down set
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`include "kwdg_cfg.svh"
`default_nettype none
module kwdg_top
   import kwdg_pkg::*;
#(
   parameter int SRESET_CYC = `KWDG_SRESET_CYC
) (
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   resetn,
   // Wishbone slave
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [`KWDG_ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [`KWDG_DAT_W-1:0] wb_dat_i,
   output logic      [`KWDG_DAT_W-1:0] wb_dat_o,
   output logic                        wb_ack_o,
   // Core events
   input  wire logic                   clear_watchdog_instruction,
   input  wire logic                   halt_instruction,
   input  wire logic                   standby_mode,
   // Slow oscillator pin
   input  wire logic                   low_speed_osc_clock,
   // Reset requests
   output logic                        device_reset_q,
   output logic                        pc_sp_reset_q,
   output logic                        pc_zero_q,
   output logic                        port_high_q,
   // Status flags
   output logic                        timeout_status_flag_q,
   output logic                        power_down_flag_q
);
   logic                   rst_s1_q;
   logic                   rst_n_q;
   logic                   osc_s;
   logic                   osc_d_q;
   logic                   tick;
   logic [7:0]             ctrl_q;
   logic [7:0]             guard_q;
   logic                   key_flag_q;
   logic                   guard_flag_q;
   kwdg_key_t              key;
   kwdg_sel_t              sel;
   kwdg_cnt_t              limit;
   kwdg_cnt_t              cnt_q;
   logic                   ovf_q;
   logic                   key_en;
   logic                   key_bad;
   logic                   guard_bad;
   kwdg_srst_t             srst_q;
   logic [31:0]            srst_cnt_q;
   logic                   cause_key_q;
   logic                   cause_guard_q;
   logic                   srst_fire;
   logic                   run_ovf;
   logic                   full_rst;
   logic                   cnt_clear;
   logic                   req;
   logic                   wr;
   logic                   clr_key_wr;
   logic                   clr_guard_wr;
   logic [`KWDG_DAT_W-1:0] rd_data;

   // Reset: asserted at once, released through two flops
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   kwdg_sync #(.W(1)) u_osc_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n_q),
      .d        (low_speed_osc_clock),
      .q        (osc_s)
   );

   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         osc_d_q <= 1'b0;
      end else begin
         osc_d_q <= osc_s;
      end
   end

   assign tick = osc_s & ~osc_d_q;

   assign key     = ctrl_q[`KWDG_KEY_MSB:`KWDG_KEY_LSB];
   assign sel     = ctrl_q[`KWDG_SEL_MSB:`KWDG_SEL_LSB];
   assign limit   = kwdg_limit(sel);
   assign key_en  = (key == `KWDG_KEY_EN);
   assign key_bad = !key_en && (key != `KWDG_KEY_DIS);
   assign guard_bad = (guard_q != `KWDG_GUARD_OK_A) && (guard_q != `KWDG_GUARD_OK_B);

   assign run_ovf   = ovf_q & ~standby_mode;
   assign srst_fire = (srst_q == KWDG_SRST_FIRE);
   assign full_rst  = srst_fire | run_ovf;
   assign cnt_clear = clear_watchdog_instruction | halt_instruction | full_rst;

   kwdg_wdcount u_count (
      .core_clk   (core_clk),
      .rst_n      (rst_n_q),
      .tick       (tick),
      .clear      (cnt_clear),
      .enable     (key_en),
      .limit      (limit),
      .count_q    (cnt_q),
      .overflow_q (ovf_q)
   );

   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         srst_q     <= KWDG_SRST_IDLE;
         srst_cnt_q <= '0;
      end else begin
         case (srst_q)
            KWDG_SRST_IDLE: begin
               srst_cnt_q <= '0;
               if (key_bad || guard_bad) begin
                  srst_q <= KWDG_SRST_WAIT;
               end
            end
            KWDG_SRST_WAIT: begin
               srst_cnt_q <= srst_cnt_q + 32'h1;
               if (srst_cnt_q >= 32'(SRESET_CYC - 1)) begin
                  srst_q <= KWDG_SRST_FIRE;
               end
            end
            KWDG_SRST_FIRE: begin
               srst_q <= KWDG_SRST_IDLE;
            end
            default: begin
               srst_q <= KWDG_SRST_IDLE;
            end
         endcase
      end
   end

   // Causes gathered while a software reset is pending
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cause_key_q   <= 1'b0;
         cause_guard_q <= 1'b0;
      end else if (srst_fire) begin
         cause_key_q   <= 1'b0;
         cause_guard_q <= 1'b0;
      end else begin
         cause_key_q   <= cause_key_q | key_bad;
         cause_guard_q <= cause_guard_q | guard_bad;
      end
   end

   // Bus request: one access per ack
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr  = req & wb_we_i & wb_sel_i[0];
   // write of zero clears a flag
   assign clr_key_wr   = wr && wb_adr_i == `KWDG_ADR_FLAGS && !wb_dat_i[`KWDG_FLAG_KEY];
   assign clr_guard_wr = wr && wb_adr_i == `KWDG_ADR_FLAGS && !wb_dat_i[`KWDG_FLAG_GUARD];

   // power-on values; full reset reloads them
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ctrl_q  <= `KWDG_CTRL_RST;
         guard_q <= `KWDG_GUARD_RST;
      end else if (full_rst) begin
         ctrl_q  <= `KWDG_CTRL_RST;
         guard_q <= `KWDG_GUARD_RST;
      end else if (wr && wb_adr_i == `KWDG_ADR_CTRL) begin
         ctrl_q <= wb_dat_i[7:0];
      end else if (wr && wb_adr_i == `KWDG_ADR_GUARD) begin
         guard_q <= wb_dat_i[7:0];
      end
   end

   // sticky reset cause flags, set wins
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         key_flag_q   <= 1'b0;
         guard_flag_q <= 1'b0;
      end else begin
         key_flag_q   <= (srst_fire & cause_key_q) | (key_flag_q & ~clr_key_wr);
         guard_flag_q <= (srst_fire & cause_guard_q) | (guard_flag_q & ~clr_guard_wr);
      end
   end

   // timeout and power-down flags, set wins
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         timeout_status_flag_q <= 1'b0;
         power_down_flag_q     <= 1'b0;
      end else begin
         timeout_status_flag_q <= ovf_q | (timeout_status_flag_q
            & ~(halt_instruction | clear_watchdog_instruction));
         power_down_flag_q <= halt_instruction
            | (power_down_flag_q & ~clear_watchdog_instruction);
      end
   end

   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         device_reset_q <= 1'b0;
         pc_sp_reset_q  <= 1'b0;
      end else begin
         device_reset_q <= full_rst;
         pc_sp_reset_q  <= ovf_q & standby_mode;
      end
   end

   // power-on preset, high until first edge after release
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pc_zero_q   <= 1'b1;
         port_high_q <= 1'b1;
      end else begin
         pc_zero_q   <= 1'b0;
         port_high_q <= 1'b0;
      end
   end

   // read mux, upper flag bits zero
   always_comb begin
      rd_data = '0;
      case (wb_adr_i)
         `KWDG_ADR_CTRL: begin
            rd_data[7:0] = ctrl_q;
         end
         `KWDG_ADR_FLAGS: begin
            rd_data[`KWDG_FLAG_GUARD] = guard_flag_q;
            rd_data[`KWDG_FLAG_KEY]   = key_flag_q;
         end
         `KWDG_ADR_GUARD: begin
            rd_data[7:0] = guard_q;
         end
         `KWDG_ADR_STAT: begin
            rd_data[`KWDG_STAT_TO]  = timeout_status_flag_q;
            rd_data[`KWDG_STAT_PDF] = power_down_flag_q;
         end
         default: begin
            rd_data = '0;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? rd_data : '0;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n_q);

   sequence s_wait_end;
      srst_q == KWDG_SRST_WAIT && srst_cnt_q >= 32'(SRESET_CYC - 1);
   endsequence
   sequence s_fire_done;
      srst_fire ##1 device_reset_q && ctrl_q == `KWDG_CTRL_RST;
   endsequence

   a_ovf_at_limit: assert property (ovf_q |-> $past(cnt_q) >= $past(limit))
      else $error("overflow before terminal count");
   a_long_period: assert property (
      (ovf_q && $past(sel) == `KWDG_SEL_LONG) |-> $past(cnt_q) == `KWDG_CNT_MAX)
      else $error("longest period not 2^18");
   a_key_disable_stops: assert property (
      (key == `KWDG_KEY_DIS && !cnt_clear) |=> cnt_q == $past(cnt_q))
      else $error("disabled watchdog counted");
   a_srst_delay_fire: assert property (s_wait_end |=> s_fire_done)
      else $error("software reset not fired after delay");
   a_key_flag_set: assert property ((srst_fire && cause_key_q) |=> key_flag_q)
      else $error("key reset flag not set");
   a_key_flag_sticky: assert property ($fell(key_flag_q) |-> $past(clr_key_wr))
      else $error("key flag cleared without write of zero");
   a_guard_flag_sticky: assert property ($fell(guard_flag_q) |-> $past(clr_guard_wr))
      else $error("guard flag cleared without write of zero");
   a_run_timeout: assert property ((ovf_q && !standby_mode) |=>
      device_reset_q && timeout_status_flag_q && ctrl_q == `KWDG_CTRL_RST)
      else $error("running timeout did not reset device");
   a_standby_timeout: assert property (
      (ovf_q && standby_mode && power_down_flag_q && !clear_watchdog_instruction) |=>
      pc_sp_reset_q && !device_reset_q && timeout_status_flag_q && power_down_flag_q)
      else $error("standby timeout wrong");
   a_halt_effect: assert property (
      (halt_instruction && !ovf_q && !clear_watchdog_instruction) |=>
      power_down_flag_q && !timeout_status_flag_q && cnt_q == '0)
      else $error("halt effects missing");
   a_reserved_zero: assert property ((req && wb_adr_i == `KWDG_ADR_FLAGS) |=>
      wb_ack_o && wb_dat_o[`KWDG_FLAG_MSB:`KWDG_FLAG_HI] == '0)
      else $error("reserved flag bits not zero");
   a_por_state: assert property ($rose(rst_n_q) |->
      ctrl_q == `KWDG_CTRL_RST && guard_q == `KWDG_GUARD_RST && pc_zero_q && port_high_q)
      else $error("power-on state wrong");
endmodule : kwdg_top
`default_nettype wire

/* File: verification/kwdg_top_test.sv */
// Self-checking bench for the keyed watchdog and reset guard top
// Assumes kwdg_cfg.svh on the include path and a short software reset delay
`include "kwdg_cfg.svh"
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module kwdg_top_test
   import kwdg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {logic [3:0] adr; logic we; logic [7:0] wd; logic [7:0] ex;} kwdg_row_t;

   logic        core_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [3:0]  wb_adr_i = 4'h0;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        clr_i = 1'b0;
   logic        halt_i = 1'b0;
   logic        standby = 1'b0;
   logic        osc = 1'b0;
   logic        osc_q = 1'b0;
   logic        osc_run = 1'b0;
   logic [1:0]  osc_div = 2'h0;
   logic        dev_rst, psp_rst, pc_zero, port_high, to_flag, pd_flag;
   logic [31:0] rd;
   int          miscompares = 0;
   int          num_checks = 0;
   int          dev_cnt = 0;
   int          psp_cnt = 0;
   int          rise_cnt = 0;
   int          cyc_cnt = 0;
   int          n, r0, e0, p0, t0;
   kwdg_row_t   rows [10];

   kwdg_top #(.SRESET_CYC(8)) i_kwdg_top (
      .core_clk(core_clk), .resetn(resetn),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .clear_watchdog_instruction(clr_i), .halt_instruction(halt_i),
      .standby_mode(standby), .low_speed_osc_clock(osc),
      .device_reset_q(dev_rst), .pc_sp_reset_q(psp_rst), .pc_zero_q(pc_zero),
      .port_high_q(port_high), .timeout_status_flag_q(to_flag),
      .power_down_flag_q(pd_flag)
   );

   always #5 core_clk = ~core_clk;

   // Slow oscillator, four core cycles a period, still when stopped
   always @(posedge core_clk) begin
      cyc_cnt <= cyc_cnt + 1;
      osc_q   <= osc;
      if (osc && !osc_q) rise_cnt <= rise_cnt + 1;
      if (dev_rst === 1'b1) dev_cnt <= dev_cnt + 1;
      if (psp_rst === 1'b1) psp_cnt <= psp_cnt + 1;
      if (osc_run) begin
         osc_div <= osc_div + 2'h1;
         if (osc_div[0]) osc <= ~osc;
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim

   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w;
      wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= 4'hf;
      do begin
         @(posedge core_clk);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
      if (k >= 50) begin
         miscompares++;
         end_sim();
      end
   endtask : wb

   task automatic wait_ev(input int lim);
      int s, k;
      s = dev_cnt + psp_cnt;
      k = 0;
      while (dev_cnt + psp_cnt == s && k < lim) begin
         @(posedge core_clk);
         k++;
      end
      if (k >= lim) begin
         miscompares++;
         end_sim();
      end
   endtask : wait_ev

   task automatic pulse(input logic h);
      @(posedge core_clk);
      if (h) halt_i <= 1'b1; else clr_i <= 1'b1;
      @(posedge core_clk);
      halt_i <= 1'b0; clr_i <= 1'b0;
   endtask : pulse

   task automatic ticks(input int t);
      repeat (4 * t) @(posedge core_clk);
   endtask : ticks

   initial begin
      rows = '{
         '{`KWDG_ADR_CTRL, 1'b0, 8'h00, 8'h53},
         '{`KWDG_ADR_GUARD, 1'b0, 8'h00, 8'h55},
         '{`KWDG_ADR_FLAGS, 1'b0, 8'h00, 8'h00},
         '{`KWDG_ADR_STAT, 1'b0, 8'h00, 8'h00},
         '{`KWDG_ADR_CTRL, 1'b1, 8'haa, 8'haa},
         '{`KWDG_ADR_CTRL, 1'b1, 8'h57, 8'h57},
         '{`KWDG_ADR_GUARD, 1'b1, 8'haa, 8'haa},
         '{`KWDG_ADR_GUARD, 1'b1, 8'h55, 8'h55},
         '{`KWDG_ADR_FLAGS, 1'b1, 8'hff, 8'h00},
         '{4'h2, 1'b1, 8'h5a, 8'h00}};
      repeat (8) @(posedge core_clk);
      `CHK("pc preset", 1'b1, pc_zero)
      `CHK("port preset", 1'b1, port_high)
      resetn <= 1'b1;
      repeat (5) @(posedge core_clk);
      `CHK("pc preset end", 1'b0, pc_zero)
      `CHK("port preset end", 1'b0, port_high)
      foreach (rows[i]) begin
         if (rows[i].we) wb(rows[i].adr, 1'b1, {24'h0, rows[i].wd});
         wb(rows[i].adr, 1'b0, 32'h0);
         `CHK("table read", {24'h0, rows[i].ex}, rd)
      end
      // Run-mode timeouts for the two shortest periods
      for (int s = 0; s < 2; s++) begin
         wb(`KWDG_ADR_CTRL, 1'b1, {24'h0, 5'h0a, 3'(s)});
         pulse(1'b0);
         r0 = rise_cnt;
         e0 = dev_cnt;
         osc_run <= 1'b1;
         wait_ev(((s == 0) ? 256 : 1024) * 4 + 100);
         osc_run <= 1'b0;
         n = rise_cnt - r0 - ((s == 0) ? 256 : 1024);
         `CHK("ticks to timeout", 1'b1, n >= 0 && n <= 2)
         `CHK("full reset", e0 + 1, dev_cnt)
         wb(`KWDG_ADR_STAT, 1'b0, 32'h0);
         `CHK("timeout flag", 32'h1, rd)
         `CHK("timeout pin", 1'b1, to_flag)
         wb(`KWDG_ADR_CTRL, 1'b0, 32'h0);
         `CHK("ctrl reloaded", 32'h53, rd)
      end
      // Clear and halt keep restarting the count
      wb(`KWDG_ADR_CTRL, 1'b1, 32'h50);
      pulse(1'b0);
      wb(`KWDG_ADR_STAT, 1'b0, 32'h0);
      `CHK("clear flags", 32'h0, rd)
      e0 = dev_cnt + psp_cnt;
      osc_run <= 1'b1;
      ticks(150);
      pulse(1'b0);
      ticks(150);
      `CHK("clear restarts", e0, dev_cnt + psp_cnt)
      pulse(1'b1);
      wb(`KWDG_ADR_STAT, 1'b0, 32'h0);
      `CHK("halt flags", 32'h2, rd)
      `CHK("halt pd pin", 1'b1, pd_flag)
      `CHK("halt to pin", 1'b0, to_flag)
      ticks(150);
      `CHK("halt restarts", e0, dev_cnt + psp_cnt)
      p0 = psp_cnt;
      standby <= 1'b1;
      wait_ev(1200);
      standby <= 1'b0;
      osc_run <= 1'b0;
      `CHK("standby reset", p0 + 1, psp_cnt)
      `CHK("no full reset", e0, dev_cnt)
      wb(`KWDG_ADR_STAT, 1'b0, 32'h0);
      `CHK("standby flags", 32'h3, rd)
      `CHK("standby to pin", 1'b1, to_flag)
      `CHK("standby pd pin", 1'b1, pd_flag)
      wb(`KWDG_ADR_CTRL, 1'b0, 32'h0);
      `CHK("ctrl kept", 32'h50, rd)
      // Disabled watchdog never fires
      wb(`KWDG_ADR_CTRL, 1'b1, 32'ha8);
      pulse(1'b0);
      e0 = dev_cnt + psp_cnt;
      osc_run <= 1'b1;
      ticks(300);
      osc_run <= 1'b0;
      `CHK("disabled", e0, dev_cnt + psp_cnt)
      // Bad key value
      wb(`KWDG_ADR_CTRL, 1'b1, 32'h00);
      t0 = cyc_cnt;
      wait_ev(100);
      n = cyc_cnt - t0;
      `CHK("key reset delay", 1'b1, n >= 8 && n <= 14)
      wb(`KWDG_ADR_FLAGS, 1'b0, 32'h0);
      `CHK("key flag", 32'h1, rd)
      wb(`KWDG_ADR_CTRL, 1'b0, 32'h0);
      `CHK("ctrl after key", 32'h53, rd)
      wb(`KWDG_ADR_FLAGS, 1'b1, 32'hff);
      wb(`KWDG_ADR_FLAGS, 1'b0, 32'h0);
      `CHK("flag write one", 32'h1, rd)
      wb(`KWDG_ADR_FLAGS, 1'b1, 32'h0);
      wb(`KWDG_ADR_FLAGS, 1'b0, 32'h0);
      `CHK("flag cleared", 32'h0, rd)
      // Bad guard value
      wb(`KWDG_ADR_GUARD, 1'b1, 32'h12);
      wait_ev(100);
      wb(`KWDG_ADR_FLAGS, 1'b0, 32'h0);
      `CHK("guard flag", 32'h8, rd)
      wb(`KWDG_ADR_GUARD, 1'b0, 32'h0);
      `CHK("guard reloaded", 32'h55, rd)
      wb(`KWDG_ADR_FLAGS, 1'b1, 32'h0);
      wb(`KWDG_ADR_FLAGS, 1'b0, 32'h0);
      `CHK("guard flag cleared", 32'h0, rd)
      // Reset in mid-run restores power-on state
      wb(`KWDG_ADR_CTRL, 1'b1, 32'haa);
      wb(`KWDG_ADR_GUARD, 1'b1, 32'haa);
      @(posedge core_clk);
      resetn <= 1'b0;
      repeat (3) @(posedge core_clk);
      `CHK("pc preset again", 1'b1, pc_zero)
      `CHK("port preset again", 1'b1, port_high)
      resetn <= 1'b1;
      repeat (5) @(posedge core_clk);
      `CHK("pc preset end again", 1'b0, pc_zero)
      `CHK("port preset end again", 1'b0, port_high)
      wb(`KWDG_ADR_CTRL, 1'b0, 32'h0);
      `CHK("ctrl after reset", 32'h53, rd)
      wb(`KWDG_ADR_GUARD, 1'b0, 32'h0);
      `CHK("guard after reset", 32'h55, rd)
      end_sim();
   end
endmodule : kwdg_top_test
`default_nettype wire
